//--- logic/srh_host.sv
// Behaviour
// - Data held across the ending edge
// - Read: both selects, gate low, strobe high
// - Read data after access time, cycle spacing
// - Selects held before end, cycle long
// - Host drives no data while device drives
// - Gate-low write cycle covers float plus setup
`timescale 1ns/1ps
`default_nettype none
module srh_host (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // Host request
  input  wire logic                      i_req_valid,
  input  wire srh_pkg::srh_req_s         i_req,
  output var  logic                      o_req_ready,
  // Read answer
  output var  logic                      o_rd_valid,
  output var  logic [srh_pkg::DATA_W-1:0] o_rd_data,
  // Memory pins
  output var  srh_pkg::srh_pins_s        o_pins,
  input  wire logic [srh_pkg::DATA_W-1:0] i_data_pins,
  output var  logic [srh_pkg::DATA_W-1:0] o_data_pins,
  output var  logic [srh_pkg::DATA_W-1:0] o_data_pins_oe_n
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_RD,
    S_WR_FLOAT,
    S_WR_LOW,
    S_WR_END
  } srh_state_e;

  srh_state_e                 state_reg,  state_next;   // Sequencer
  logic [srh_pkg::CNT_W-1:0]  cnt_reg,    cnt_next;     // Phase counter
  srh_pkg::srh_req_s          req_reg,    req_next;     // Latched request
  srh_pkg::srh_pins_s         pins_reg,   pins_next;    // Control pins
  logic [srh_pkg::DATA_W-1:0] dout_reg,   dout_next;    // Write data
  logic                       doe_n_reg,  doe_n_next;   // Data enable, low drives
  logic                       ready_reg,  ready_next;   // Request ready
  logic                       rdv_reg,    rdv_next;     // Read valid pulse
  logic [srh_pkg::DATA_W-1:0] rdd_reg,    rdd_next;     // Read data

  // Idle pin pattern: deselected, strobe and gate inactive
  function automatic srh_pkg::srh_pins_s idle_pins(input logic [srh_pkg::ADDR_W-1:0] a);
    srh_pkg::srh_pins_s p;
    p.select_active_low_n = 1'b1;
    p.select_active_high  = 1'b0;
    p.write_strobe_n      = 1'b1;
    p.output_gate_n       = 1'b1;
    p.address_pins        = a;
    return p;
  endfunction

  // Phase counter one step down
  function automatic logic [srh_pkg::CNT_W-1:0] cnt_dec(input logic [srh_pkg::CNT_W-1:0] c);
    return c - srh_pkg::CNT_ONE;
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    req_next   = req_reg;
    pins_next  = pins_reg;
    dout_next  = dout_reg;
    doe_n_next = doe_n_reg;
    ready_next = ready_reg;
    rdv_next   = 1'b0;
    rdd_next   = rdd_reg;
    case (state_reg)
      // Wait for a request
      S_IDLE: begin
        if (i_req_valid && ready_reg) begin
          req_next   = i_req;
          ready_next = 1'b0;
          pins_next  = idle_pins(i_req.addr);
          pins_next.select_active_low_n = 1'b0;
          pins_next.select_active_high  = 1'b1;
          if (!i_req.write) begin
            pins_next.output_gate_n = 1'b0;
            cnt_next   = 4'(srh_pkg::RD_WAIT_CYC);
            state_next = S_RD;
          end else if (i_req.wmode == srh_pkg::WR_SELECT) begin
            // Strobe first; selects then open the write
            pins_next.select_active_low_n = 1'b1;
            pins_next.select_active_high  = 1'b0;
            pins_next.write_strobe_n      = 1'b0;
            dout_next  = i_req.wdata;
            doe_n_next = 1'b0;
            cnt_next   = 4'(srh_pkg::WR_LOW_CYC);
            state_next = S_WR_FLOAT;
          end else if (i_req.wmode == srh_pkg::WR_STROBE_GATE_LOW) begin
            // gate held low, wait for float
            pins_next.output_gate_n  = 1'b0;
            pins_next.write_strobe_n = 1'b0;
            cnt_next   = 4'(srh_pkg::WR_FLT_CYC);
            state_next = S_WR_FLOAT;
          end else begin
            // Gate high, pins already floating
            pins_next.write_strobe_n = 1'b0;
            dout_next  = i_req.wdata;
            doe_n_next = 1'b0;
            cnt_next   = 4'(srh_pkg::WR_LOW_CYC);
            state_next = S_WR_LOW;
          end
        end
      end
      S_RD: begin
        if (cnt_reg == srh_pkg::CNT_ONE) begin
          // Access time met: capture the byte, deselect
          rdd_next   = i_data_pins;
          rdv_next   = 1'b1;
          pins_next  = idle_pins(req_reg.addr);
          ready_next = 1'b1;
          state_next = S_IDLE;
        end else begin
          // Access time not yet met
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      // Float wait or select-controlled prelude
      S_WR_FLOAT: begin
        if (req_reg.wmode == srh_pkg::WR_SELECT) begin
          pins_next.select_active_low_n = 1'b0;
          pins_next.select_active_high  = 1'b1;
          state_next = S_WR_LOW;
        end else if (cnt_reg == srh_pkg::CNT_ONE) begin
          dout_next  = req_reg.wdata;
          doe_n_next = 1'b0;
          cnt_next   = 4'(srh_pkg::WR_LOW_CYC);
          state_next = S_WR_LOW;
        end else begin
          // Float time not yet met
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      S_WR_LOW: begin
        if (cnt_reg == srh_pkg::CNT_ONE) begin
          if (req_reg.wmode == srh_pkg::WR_SELECT) begin
            pins_next.select_active_low_n = 1'b1;
            pins_next.select_active_high  = 1'b0;
          end else begin
            pins_next.write_strobe_n = 1'b1;
            pins_next.output_gate_n  = 1'b1;
          end
          state_next = S_WR_END;
        end else begin
          // Overlap not yet long enough
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      S_WR_END: begin
        doe_n_next = 1'b1;
        pins_next  = idle_pins(req_reg.addr);
        ready_next = 1'b1;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
        pins_next  = idle_pins('0);
        doe_n_next = 1'b1;
        ready_next = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    // Reset: deselected, strobes off, data pins released
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= '0;
      req_reg   <= '0;
      pins_reg  <= '{select_active_low_n: 1'b1, select_active_high: 1'b0,
                     write_strobe_n: 1'b1, output_gate_n: 1'b1, address_pins: '0};
      dout_reg  <= '0;
      doe_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      rdv_reg   <= 1'b0;
      rdd_reg   <= '0;
    end else begin
      // Every register advances on each edge
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      req_reg   <= req_next;
      pins_reg  <= pins_next;
      dout_reg  <= dout_next;
      doe_n_reg <= doe_n_next;
      ready_reg <= ready_next;
      rdv_reg   <= rdv_next;
      rdd_reg   <= rdd_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_pins           = pins_reg;
  assign o_data_pins      = dout_reg;
  assign o_data_pins_oe_n = {srh_pkg::DATA_W{doe_n_reg}};
  assign o_req_ready      = ready_reg;
  assign o_rd_valid       = rdv_reg;
  assign o_rd_data        = rdd_reg;
endmodule
`default_nettype wire

//--- logic/srh_pkg.sv
`default_nettype none
// -----------------------------------------------------------------------------
// Shared constants and types of the static memory host port
// -----------------------------------------------------------------------------
package srh_pkg;
  // Geometry of the attached memory
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH  = 8192;

  // Clock rate
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Device timing figures, ns
  localparam int unsigned READ_CYCLE_MIN_NS          = 15;
  localparam int unsigned ADDRESS_ACCESS_TIME_NS     = 15;
  localparam int unsigned GATE_ACCESS_TIME_NS        = 8;
  localparam int unsigned OUTPUT_HOLD_AFTER_ADDR_NS  = 3;
  localparam int unsigned WRITE_CYCLE_MIN_NS         = 15;
  localparam int unsigned SELECT_BEFORE_WRITE_END_NS = 12;
  localparam int unsigned STROBE_TO_FLOAT_DELAY_NS   = 7;
  localparam int unsigned DATA_VALID_BEFORE_END_NS   = 8;
  localparam int unsigned DESELECT_TO_SLEEP_DELAY_NS = 15;

  // Least time in cycles, rounded up, at least one
  function automatic int unsigned min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Derived cycle counts
  localparam int unsigned RD_WAIT_CYC = min_cycles(ADDRESS_ACCESS_TIME_NS);
  localparam int unsigned WR_LOW_CYC  = min_cycles(SELECT_BEFORE_WRITE_END_NS);
  localparam int unsigned WR_FLT_CYC  = min_cycles(STROBE_TO_FLOAT_DELAY_NS
                                                   + DATA_VALID_BEFORE_END_NS);
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Write variants
  typedef enum logic [1:0] {
    WR_STROBE,
    WR_SELECT,
    WR_STROBE_GATE_LOW
  } srh_wmode_e;

  // Pins toward the memory
  typedef struct packed {
    logic              select_active_low_n;
    logic              select_active_high;
    logic              write_strobe_n;
    logic              output_gate_n;
    logic [ADDR_W-1:0] address_pins;
  } srh_pins_s;

  // Host-side request
  typedef struct packed {
    logic              write;
    srh_wmode_e        wmode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srh_req_s;
endpackage
`default_nettype wire

//--- sim/srh_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Behavioural static memory
// ----
module srh_sram_model (
  // Pins from the host
  input  wire srh_pkg::srh_pins_s i_pins,
  input  wire logic [7:0]         i_host_data,
  input  wire logic [7:0]         i_host_oe_n,
  // Data back to the host
  output wire logic [7:0]         o_data
);
  logic [7:0] mem [0:srh_pkg::DEPTH-1];
  logic [7:0] last = 8'h5a;
  logic       sel, wr_on, rd_on;
  assign sel = !i_pins.select_active_low_n && i_pins.select_active_high;
  assign wr_on = sel && !i_pins.write_strobe_n;
  assign rd_on = sel && i_pins.write_strobe_n && !i_pins.output_gate_n;
  always @(wr_on or i_pins or i_host_data or i_host_oe_n)
    if (wr_on && i_host_oe_n == 8'h00) mem[i_pins.address_pins] = i_host_data;
  // Latch the addressed byte while reading
  always @(rd_on or i_pins)
    if (rd_on) last = mem[i_pins.address_pins];
  // float shows inverse, late and held data
  assign #(srh_pkg::GATE_ACCESS_TIME_NS) o_data = rd_on ? last : ~last;
endmodule
`default_nettype wire

//--- sim/srh_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module srh_chk (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  // Host side
  input wire logic               i_req_valid,
  input wire srh_pkg::srh_req_s  i_req,
  input wire logic               o_req_ready,
  input wire logic               o_rd_valid,
  // Memory side
  input wire srh_pkg::srh_pins_s o_pins,
  input wire logic [7:0]         o_data_pins,
  input wire logic [7:0]         o_data_pins_oe_n
);
  logic take, sel;
  assign take = i_req_valid && o_req_ready;
  assign sel = !o_pins.select_active_low_n && o_pins.select_active_high;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rd_pins;
    take && !i_req.write |=> sel && !o_pins.output_gate_n && o_pins.write_strobe_n;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pins wrong");
  property p_rd_valid;
    take && !i_req.write |-> ##2 o_rd_valid ##1 !o_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer late");
  property p_no_clash;
    sel && !o_pins.output_gate_n && o_pins.write_strobe_n |-> o_data_pins_oe_n == 8'hff;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus clash");
  property p_wr_len;
    take && i_req.write && i_req.wmode == srh_pkg::WR_STROBE
      |=> !o_req_ready [*2] ##1 o_req_ready;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write length");
  property p_gl_order;
    take && i_req.write && i_req.wmode == srh_pkg::WR_STROBE_GATE_LOW
      |=> o_data_pins_oe_n == 8'hff ##1 o_data_pins_oe_n == 8'h00 ##2 o_req_ready;
  endproperty
  a_gl_order: assert property (p_gl_order) else $error("gate-low write order");
  property p_hold_we;
    $rose(o_pins.write_strobe_n) && sel |-> o_data_pins_oe_n == 8'h00 && $stable(o_data_pins);
  endproperty
  a_hold_we: assert property (p_hold_we) else $error("data not held");
  property p_hold_sel;
    $fell(sel) && !o_pins.write_strobe_n |-> o_data_pins_oe_n == 8'h00;
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("data not held");
  property p_sel_end;
    $rose(o_pins.write_strobe_n) && sel |-> $past(sel);
  endproperty
  a_sel_end: assert property (p_sel_end) else $error("select too short");
  property p_addr;
    sel && $past(sel) |-> $stable(o_pins.address_pins);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind srh_host srh_chk u_chk (.i_clk, .i_rst_n, .i_req_valid, .i_req, .o_req_ready,
  .o_rd_valid, .o_pins, .o_data_pins, .o_data_pins_oe_n);
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, o_req_ready, o_rd_valid;
  srh_pkg::srh_req_s  i_req = '0;
  srh_pkg::srh_pins_s o_pins;
  logic [7:0] o_rd_data, o_data_pins, o_data_pins_oe_n, mdl_data, bus;
  int miscompares = 0, n_tests = 0;
  always #25 i_clk = ~i_clk;
  // Wire level from both drivers
  assign bus = (~o_data_pins_oe_n & o_data_pins) | (o_data_pins_oe_n & mdl_data);
  srh_host dut (.i_clk, .i_rst_n, .i_req_valid, .i_req, .o_req_ready, .o_rd_valid,
    .o_rd_data, .o_pins, .i_data_pins(bus), .o_data_pins, .o_data_pins_oe_n);
  srh_sram_model u_mem (.i_pins(o_pins), .i_host_data(o_data_pins),
    .i_host_oe_n(o_data_pins_oe_n), .o_data(mdl_data));
  task automatic check(input string what, input logic [16:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One request, held until taken
  task automatic req(input logic wr, input logic [1:0] m, input logic [12:0] a,
                     input logic [7:0] d);
    int n = 0;
    i_req = '{wr, srh_pkg::srh_wmode_e'(m), a, d};
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && n++ < 20) @(posedge i_clk) #1;
    check("ready", {16'h0000, o_req_ready}, 17'h00001);
    @(posedge i_clk) #1;
    i_req_valid = 1'b0;
    // Let an edge pass before the next request
    @(posedge i_clk) #1;
  endtask
  // Read and compare
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    int n = 0;
    req(1'b0, 2'd0, a, 8'h00);
    while (o_rd_valid !== 1'b1 && n++ < 10) @(posedge i_clk) #1;
    check("read valid", {16'h0000, o_rd_valid}, 17'h00001);
    check("read data", {9'h000, o_rd_data}, {9'h000, exp});
  endtask
  task automatic t_reset();
    check("idle pins", o_pins, {4'hb, 13'h0000});
    check("oe_n", {9'h000, o_data_pins_oe_n}, 17'h000ff);
    check("ready", {16'h0000, o_req_ready}, 17'h00001);
    $display("test reset done");
  endtask
  task automatic t_modes();
    logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    for (int m = 0; m < 4; m++) req(1'b1, 2'(m), a[m], 8'h3c ^ 8'(m));
    for (int m = 0; m < 4; m++) rd(a[m], 8'h3c ^ 8'(m));
    $display("test modes done");
  endtask
  task automatic t_keep();
    req(1'b1, 2'd1, 13'h0aaa, 8'h81);
    req(1'b1, 2'd2, 13'h0aaa, 8'h7e);
    rd(13'h0aaa, 8'h7e);
    repeat (40) @(posedge i_clk);
    #1 rd(13'h0aaa, 8'h7e);
    $display("test keep done");
  endtask
  task automatic t_refuse();
    req(1'b1, 2'd0, 13'h0001, 8'h55);
    // Write still busy: this request must be ignored
    i_req = '{1'b1, srh_pkg::WR_STROBE, 13'h0001, 8'hee};
    i_req_valid = 1'b1;
    check("busy", {16'h0000, o_req_ready}, 17'h00000);
    @(posedge i_clk) #1;
    i_req_valid = 1'b0;
    @(posedge i_clk) #1;
    rd(13'h0001, 8'h55);
    $display("test refuse done");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    t_reset();
    t_modes();
    t_keep();
    t_refuse();
    stop_test();
  end
  // Watchdog
  initial begin
    #50000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
